// [rtl/ips_interrupt_priority_select.sv]
// Interrupt priority level register, byte and bit addressable.
`timescale 1ns/100ps
`default_nettype none
`include "ips_map.svh"
module ips_interrupt_priority_select
    import ips_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Byte access in special function register space
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    output logic [7:0] sfrRdData,
    // Bit access, bitAddr[2:0] selects the bit, upper bits the byte
    input wire logic [7:0] bitAddr,
    input wire logic bitWrEn,
    input wire logic bitWrVal,
    output logic bitRdVal,
    // Priority levels towards the arbiter
    output logic serial_periph_irq_high_level,
    output logic timer2_irq_high_level,
    output logic uart_irq_high_level,
    output logic timer1_irq_high_level,
    output logic ext_irq1_high_level,
    output logic timer0_irq_high_level,
    output logic ext_irq0_high_level
);
    // ****************************************
    // Decode and storage
    // ****************************************
    logic byteHit;
    logic bitHit;
    ips_levels_t levels;
    ips_byte_t regView;

    assign byteHit = sfrWrEn && (sfrAddr == `IPS_SFR_ADDR);
    assign bitHit = bitWrEn && ({bitAddr[7:3], 3'h0} == `IPS_SFR_ADDR);

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_cell
            ips_bit_cell u_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .byteWr(byteHit),
                .byteVal(sfrWrData[gi]),
                .bitWr(bitHit && (bitAddr[2:0] == 3'(gi))),
                .bitVal(bitWrVal),
                .level_q(levels[gi])
            );
        end
    endgenerate

    // Unused top bit is constant one; writes never reach it.
    assign regView = {1'b1, levels};

    // ****************************************
    // Read path, registered data
    // ****************************************
    logic [7:0] rdData_q;
    logic bitRd_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_q <= `IPS_RESET_VAL;
        end else if (sfrRdEn && (sfrAddr == `IPS_SFR_ADDR)) begin
            rdData_q <= regView;
        end else if (sfrRdEn) begin
            rdData_q <= 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bitRd_q <= 1'b0;
        end else if ({bitAddr[7:3], 3'h0} == `IPS_SFR_ADDR) begin
            bitRd_q <= regView[bitAddr[2:0]];
        end else begin
            bitRd_q <= 1'b0;
        end
    end

    assign sfrRdData = rdData_q;
    assign bitRdVal = bitRd_q;

    // ****************************************
    // Level outputs
    // ****************************************
    assign serial_periph_irq_high_level = levels[`IPS_BIT_SPI];
    assign timer2_irq_high_level = levels[`IPS_BIT_T2];
    assign uart_irq_high_level = levels[`IPS_BIT_UART];
    assign timer1_irq_high_level = levels[`IPS_BIT_T1];
    assign ext_irq1_high_level = levels[`IPS_BIT_EX1];
    assign timer0_irq_high_level = levels[`IPS_BIT_T0];
    assign ext_irq0_high_level = levels[`IPS_BIT_EX0];

    // ****************************************
    // Checks
    // ****************************************
    property p_top_one;
        @(posedge sys_clk) disable iff (rst)
        sfrRdEn && (sfrAddr == `IPS_SFR_ADDR) |=> sfrRdData[7];
    endproperty
    a_top_one: assert property (p_top_one)
        else $error("Unused top bit did not read one.");

    property p_spi;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> serial_periph_irq_high_level == $past(sfrWrData[6]);
    endproperty
    a_spi: assert property (p_spi)
        else $error("Serial peripheral level not written.");

    property p_t2;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> timer2_irq_high_level == $past(sfrWrData[5]);
    endproperty
    a_t2: assert property (p_t2)
        else $error("Timer 2 level not written.");

    property p_uart;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> uart_irq_high_level == $past(sfrWrData[4]);
    endproperty
    a_uart: assert property (p_uart)
        else $error("UART level not written.");

    property p_t1;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> timer1_irq_high_level == $past(sfrWrData[3]);
    endproperty
    a_t1: assert property (p_t1)
        else $error("Timer 1 level not written.");

    property p_ex1;
        @(posedge sys_clk) disable iff (rst)
        bitHit && bitAddr[2:0] == 3'h2
        |=> ext_irq1_high_level == $past(bitWrVal);
    endproperty
    a_ex1: assert property (p_ex1)
        else $error("External 1 level not bit written.");

    property p_t0;
        @(posedge sys_clk) disable iff (rst)
        !byteHit && !bitHit |=> $stable(timer0_irq_high_level);
    endproperty
    a_t0: assert property (p_t0)
        else $error("Timer 0 level changed without write.");

    property p_ex0;
        @(posedge sys_clk) disable iff (rst)
        sfrRdEn && (sfrAddr == `IPS_SFR_ADDR)
        |=> sfrRdData[0] == $past(ext_irq0_high_level);
    endproperty
    a_ex0: assert property (p_ex0)
        else $error("External 0 level read back wrong.");

    property p_bit_top;
        @(posedge sys_clk) disable iff (rst)
        ({bitAddr[7:3], 3'h0} == `IPS_SFR_ADDR) &&
        (bitAddr[2:0] == `IPS_BIT_UNUSED)
        |=> bitRdVal;
    endproperty
    a_bit_top: assert property (p_bit_top)
        else $error("Unused top bit did not read one by bit.");

    property p_spi_bit;
        @(posedge sys_clk) disable iff (rst)
        bitHit && (bitAddr[2:0] == `IPS_BIT_SPI)
        |=> serial_periph_irq_high_level == $past(bitWrVal);
    endproperty
    a_spi_bit: assert property (p_spi_bit)
        else $error("Serial peripheral level not bit written.");

    property p_t2_bit;
        @(posedge sys_clk) disable iff (rst)
        bitHit && (bitAddr[2:0] == `IPS_BIT_T2)
        |=> timer2_irq_high_level == $past(bitWrVal);
    endproperty
    a_t2_bit: assert property (p_t2_bit)
        else $error("Timer 2 level not bit written.");

    property p_uart_bit;
        @(posedge sys_clk) disable iff (rst)
        bitHit && (bitAddr[2:0] == `IPS_BIT_UART)
        |=> uart_irq_high_level == $past(bitWrVal);
    endproperty
    a_uart_bit: assert property (p_uart_bit)
        else $error("UART level not bit written.");

    property p_t1_bit;
        @(posedge sys_clk) disable iff (rst)
        bitHit && (bitAddr[2:0] == `IPS_BIT_T1)
        |=> timer1_irq_high_level == $past(bitWrVal);
    endproperty
    a_t1_bit: assert property (p_t1_bit)
        else $error("Timer 1 level not bit written.");

    property p_ex1_byte;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> ext_irq1_high_level == $past(sfrWrData[`IPS_BIT_EX1]);
    endproperty
    a_ex1_byte: assert property (p_ex1_byte)
        else $error("External 1 level not byte written.");

    property p_t0_byte;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> timer0_irq_high_level == $past(sfrWrData[`IPS_BIT_T0]);
    endproperty
    a_t0_byte: assert property (p_t0_byte)
        else $error("Timer 0 level not byte written.");

    property p_ex0_byte;
        @(posedge sys_clk) disable iff (rst)
        byteHit && !bitHit
        |=> ext_irq0_high_level == $past(sfrWrData[`IPS_BIT_EX0]);
    endproperty
    a_ex0_byte: assert property (p_ex0_byte)
        else $error("External 0 level not byte written.");
endmodule // ips_interrupt_priority_select
`default_nettype wire

// [rtl/ips_map.svh]
// Offsets, field positions and reset value of the priority register.
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH
`define IPS_SFR_ADDR 8'hb8
`define IPS_RESET_VAL 8'h80
`define IPS_BIT_UNUSED 3'h7
`define IPS_BIT_SPI 3'h6
`define IPS_BIT_T2 3'h5
`define IPS_BIT_UART 3'h4
`define IPS_BIT_T1 3'h3
`define IPS_BIT_EX1 3'h2
`define IPS_BIT_T0 3'h1
`define IPS_BIT_EX0 3'h0
`endif

// [rtl/ips_pkg.sv]
// Types shared by the priority select block.
`default_nettype none
package ips_pkg;
    typedef logic [7:0] ips_byte_t;
    typedef logic [6:0] ips_levels_t;
endpackage
`default_nettype wire

// [rtl/ips_bit_cell.sv]
// One storage cell of the priority register.
`timescale 1ns/100ps
`default_nettype none
module ips_bit_cell (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Write controls
    input wire logic byteWr,
    input wire logic byteVal,
    input wire logic bitWr,
    input wire logic bitVal,
    // Stored level
    output logic level_q
);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (bitWr) begin
            level_q <= bitVal;
        end else if (byteWr) begin
            level_q <= byteVal;
        end
    end
endmodule // ips_bit_cell
`default_nettype wire

// [dv/ips_interrupt_priority_select_tb.sv]
// Self-checking bench for the interrupt priority register.
`timescale 1ns/100ps
`default_nettype none
`include "ips_map.svh"
module ips_interrupt_priority_select_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrEn = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrRdEn = 1'b0;
    logic [7:0] sfrRdData;
    logic [7:0] bitAddr = 8'h00;
    logic bitWrEn = 1'b0;
    logic bitWrVal = 1'b0;
    logic bitRdVal;
    wire [6:0] lv;
    logic [7:0] r;
    int mismatches = 0;
    int checks_done = 0;
    int m = 0;
    int i;
    ips_interrupt_priority_select u_ips_interrupt_priority_select (
        .sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
        .sfrRdData(sfrRdData), .bitAddr(bitAddr), .bitWrEn(bitWrEn),
        .bitWrVal(bitWrVal), .bitRdVal(bitRdVal),
        .serial_periph_irq_high_level(lv[6]),
        .timer2_irq_high_level(lv[5]), .uart_irq_high_level(lv[4]),
        .timer1_irq_high_level(lv[3]), .ext_irq1_high_level(lv[2]),
        .timer0_irq_high_level(lv[1]), .ext_irq0_high_level(lv[0]));
    always #20 sys_clk = ~sys_clk;
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        tick;
        sfrWrEn = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        tick;
        sfrRdEn = 1'b0;
        chk(sfrRdData, e);
    endtask
    // Compares the level outputs and a byte read with the model.
    task look;
        chk({5'h00, lv[6:4]}, {5'h00, m[6:4]});
        chk({4'h0, lv[3:0]}, {4'h0, m[3:0]});
        rd(`IPS_SFR_ADDR, {1'b1, m[6:0]});
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        void'($urandom(32'h30b7));
        repeat (16) tick;
        rst = 1'b0;
        tick;
        look();
        $display("test reset done");
        for (i = 0; i < 20; i++) begin
            r = 8'($urandom);
            wr(`IPS_SFR_ADDR, r);
            m = r[6:0];
            look();
        end
        wr(8'hb9, ~r);
        rd(8'hb9, 8'h00);
        tick;
        look();
        $display("test byte access done");
        for (i = 0; i < 8; i++) begin
            bitAddr = 8'hb8 | i[7:0];
            bitWrVal = 1'($urandom);
            bitWrEn = 1'b1;
            tick;
            bitWrEn = 1'b0;
            if (i < 7) m[i] = bitWrVal;
            tick;
            r = (i == 7) ? 8'h01 : {7'h00, m[i]};
            chk({7'h00, bitRdVal}, r);
            look();
        end
        bitAddr = 8'h20;
        tick;
        chk({7'h00, bitRdVal}, 8'h00);
        $display("test bit access done");
        bitAddr = 8'hbb;
        bitWrVal = 1'b0;
        bitWrEn = 1'b1;
        wr(`IPS_SFR_ADDR, 8'h7f);
        bitWrEn = 1'b0;
        m = 32'h77;
        look();
        rst = 1'b1;
        tick;
        rst = 1'b0;
        m = 0;
        chk(sfrRdData, `IPS_RESET_VAL);
        look();
        $display("test collision and reset done");
        results();
    end
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule // ips_interrupt_priority_select_tb
`default_nettype wire
